/* hdl/pscb_bank.v */
// Device state control register bank with key-gated peripheral enables.
//
// What this block does
// - Exact key on the unlock register opens a 16-cycle window for configuration A.
// - Only the first configuration A write inside an open window is taken.
// - The unlock register is one 32-bit read/write value compared with the key.
// - Only the processor core or the emulator may read or write this bank.
// - Bit 20 enables PCI; defaults to one when boot select is 0111b.
// - Bit 18 enables the host port; defaults to one when boot select is 0001b.
// - Bit 16 enables serial port one.
// - Bit 14 enables serial port zero.
// - Bit 12 enables the I2C controller.
// - Bit 10 enables the general-purpose I/O unit.
// - Bit 8 enables timer zero.
// - Bit 6 enables timer one.
// - Bit 4 enables the Ethernet MAC and its management interface.
// - After reset peripherals start disabled; boot peripherals are enabled automatically unless their static powerdown strap is set.
// - Configuration B accepts writes directly, with no key.
// - Status fields read 000 disabled, 001 enabled, 011 powerdown, 101 in progress.
`timescale 1ns/100ps
`include "pscb_consts.vh"

module pscb_bank #(
    parameter WINDOW_CYCLES = `PSCB_WINDOW_CYCLES,
    parameter ENABLE_CYCLES = `PSCB_ENABLE_CYCLES
) (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        bus_req,
    input  wire        bus_we,
    input  wire [31:0] bus_addr,
    input  wire [31:0] bus_wdata,
    input  wire [1:0]  bus_master,
    output reg  [31:0] bus_rdata,
    output reg         bus_rvalid,
    output reg         bus_refused,
    input  wire [3:0]  boot_select_field,
    input  wire        pd_strap_host_port,
    input  wire        pd_strap_pci,
    input  wire        pd_strap_serial_one,
    input  wire        pd_strap_mac,
    output wire [8:0]  periph_enable,
    output wire        config_a_unlocked,
    output reg  [31:0] mac_interface_config,
    output reg  [31:0] peripheral_enable_config_b,
    output reg  [31:0] emulator_buffer_powerdown
);

    localparam NPERIPH = 9;
    localparam [4:0] WIN_LOAD = WINDOW_CYCLES;
    localparam [1:0] SET_LAST = `PSCB_STRAP_SETTLE - 1;

    // ------------------------------------------------------------------------
    // Peripheral index to enable bit position.
    // ------------------------------------------------------------------------
    function integer ctl_pos;
        input integer idx;
        begin
            case (idx)
                0:       ctl_pos = `PSCB_BIT_HOST_PORT;
                1:       ctl_pos = `PSCB_BIT_SERIAL_ONE;
                2:       ctl_pos = `PSCB_BIT_SERIAL_ZERO;
                3:       ctl_pos = `PSCB_BIT_I2C;
                4:       ctl_pos = `PSCB_BIT_GPIO;
                5:       ctl_pos = `PSCB_BIT_TIMER_ONE;
                6:       ctl_pos = `PSCB_BIT_TIMER_ZERO;
                7:       ctl_pos = `PSCB_BIT_MAC;
                default: ctl_pos = `PSCB_BIT_PCI;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Peripheral index to status field low bit.
    // ------------------------------------------------------------------------
    function integer stat_pos;
        input integer idx;
        begin
            case (idx)
                0:       stat_pos = `PSCB_STAT_HOST_PORT;
                1:       stat_pos = `PSCB_STAT_SERIAL_ONE;
                2:       stat_pos = `PSCB_STAT_SERIAL_ZERO;
                3:       stat_pos = `PSCB_STAT_I2C;
                4:       stat_pos = `PSCB_STAT_GPIO;
                5:       stat_pos = `PSCB_STAT_TIMER_ONE;
                6:       stat_pos = `PSCB_STAT_TIMER_ZERO;
                7:       stat_pos = `PSCB_STAT_MAC;
                default: stat_pos = `PSCB_STAT_PCI;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Address decode used by the write paths; the read multiplexer compares the address itself.
    // ------------------------------------------------------------------------
    function hit;
        input [31:0] addr;
        input [31:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    reg  [7:0]  strap_meta_reg;
    reg  [7:0]  strap_sync_reg;
    reg  [1:0]  settle_reg;
    reg         strap_done_reg;
    reg  [3:0]  boot_sel_reg;
    reg  [8:0]  static_pd_reg;
    reg  [31:0] peripheral_unlock_key;
    reg  [31:0] peripheral_enable_config_a;
    reg  [4:0]  window_reg;
    reg  [31:0] rdata_next;
    reg  [31:0] status_a_word;
    reg  [31:0] status_b_word;
    wire [2:0]  periph_status [0:NPERIPH-1];
    wire [8:0]  mode_ctl;
    wire        allowed;
    wire        wr_ok;
    wire        key_write;
    wire        cfg_a_write;
    wire        window_open;
    wire [1:0]  settle_last;
    integer     k;

    // ------------------------------------------------------------------------
    // Strap synchroniser: boot select and static powerdown pins.
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            strap_meta_reg <= 8'h00;
            strap_sync_reg <= 8'h00;
        end else begin
            strap_meta_reg <= {pd_strap_mac, pd_strap_serial_one, pd_strap_pci,
                               pd_strap_host_port, boot_select_field};
            strap_sync_reg <= strap_meta_reg;
        end
    end

    assign settle_last = SET_LAST;

    // ------------------------------------------------------------------------
    // Straps are caught once, after the synchroniser has filled post-reset.
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            settle_reg     <= 2'h0;
            strap_done_reg <= 1'b0;
            boot_sel_reg   <= 4'h0;
            static_pd_reg  <= 9'h000;
        end else if (!strap_done_reg) begin
            if (settle_reg == settle_last) begin
                strap_done_reg   <= 1'b1;
                boot_sel_reg     <= strap_sync_reg[3:0];
                static_pd_reg[0] <= strap_sync_reg[4];
                static_pd_reg[8] <= strap_sync_reg[5];
                static_pd_reg[1] <= strap_sync_reg[6];
                static_pd_reg[7] <= strap_sync_reg[7];
            end else begin
                settle_reg <= settle_reg + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Access qualification: only the core and the emulator reach the bank.
    // ------------------------------------------------------------------------
    assign allowed     = (bus_master == `PSCB_MASTER_CPU) ||
                         (bus_master == `PSCB_MASTER_EMU);
    assign wr_ok       = bus_req && bus_we && allowed;
    assign key_write   = wr_ok && hit(bus_addr, `PSCB_ADDR_UNLOCK_KEY);
    assign cfg_a_write = wr_ok && hit(bus_addr, `PSCB_ADDR_CONFIG_A);
    assign window_open = (window_reg != 5'h00);
    assign config_a_unlocked = window_open;

    // ------------------------------------------------------------------------
    // Unlock register and window counter.
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            peripheral_unlock_key <= `PSCB_UNLOCK_RESET;
            window_reg            <= 5'h00;
        end else begin
            if (key_write) begin
                peripheral_unlock_key <= bus_wdata;
                if (bus_wdata == `PSCB_UNLOCK_KEY) begin
                    window_reg <= WIN_LOAD;
                end else begin
                    window_reg <= 5'h00;
                end
            end else if (cfg_a_write && window_open) begin
                window_reg <= 5'h00;
            end else if (window_open) begin
                window_reg <= window_reg - 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Configuration A: one gated write per unlock, boot defaults after reset.
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            peripheral_enable_config_a <= `PSCB_CONFIG_A_RESET;
        end else if (strap_done_reg == 1'b0 && settle_reg == settle_last) begin
            if (strap_sync_reg[3:0] == `PSCB_BOOT_PCI) begin
                peripheral_enable_config_a[`PSCB_BIT_PCI] <= 1'b1;
            end
            if (strap_sync_reg[3:0] == `PSCB_BOOT_HOST_PORT) begin
                peripheral_enable_config_a[`PSCB_BIT_HOST_PORT] <= 1'b1;
            end
        end else if (cfg_a_write && window_open) begin
            peripheral_enable_config_a <= bus_wdata & `PSCB_CONFIG_A_MASK;
        end
    end

    // ------------------------------------------------------------------------
    // Plain registers: configuration B, MAC configuration, emulator powerdown.
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            peripheral_enable_config_b <= `PSCB_PLAIN_RESET;
            mac_interface_config       <= `PSCB_PLAIN_RESET;
            emulator_buffer_powerdown  <= `PSCB_PLAIN_RESET;
        end else if (wr_ok) begin
            if (hit(bus_addr, `PSCB_ADDR_CONFIG_B)) begin
                peripheral_enable_config_b <= bus_wdata;
            end
            if (hit(bus_addr, `PSCB_ADDR_MAC_CONFIG)) begin
                mac_interface_config <= bus_wdata;
            end
            if (hit(bus_addr, `PSCB_ADDR_EMU_PD)) begin
                emulator_buffer_powerdown <= bus_wdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // One state tracker per peripheral, steered by its enable bit.
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NPERIPH; g = g + 1) begin : gen_periph
            // Bits 20,18,16,14,12,10,8,6,4 select the peripherals.
            assign mode_ctl[g] = peripheral_enable_config_a[ctl_pos(g)];
            pscb_periph_state #(
                .LATENCY       (ENABLE_CYCLES)
            ) u_state (
                .clk_sys       (clk_sys),
                .rst           (rst),
                .mode_ctl      (mode_ctl[g]),
                .static_pd     (static_pd_reg[g]),
                .periph_enable (periph_enable[g]),
                .periph_status (periph_status[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Status words assembled from the trackers; unused bits read zero.
    // ------------------------------------------------------------------------
    always @* begin
        status_a_word = 32'h00000000;
        status_b_word = 32'h00000000;
        for (k = 0; k < NPERIPH - 1; k = k + 1) begin
            status_a_word[stat_pos(k) +: 3] = periph_status[k];
        end
        status_b_word[`PSCB_STAT_PCI +: 3] = periph_status[NPERIPH-1];
    end

    // ------------------------------------------------------------------------
    // Read multiplexer; reserved and unmapped addresses read zero.
    // ------------------------------------------------------------------------
    always @* begin
        rdata_next = 32'h00000000;
        case (bus_addr)
            `PSCB_ADDR_UNLOCK_KEY: rdata_next = peripheral_unlock_key;
            `PSCB_ADDR_CONFIG_A:   rdata_next = peripheral_enable_config_a;
            `PSCB_ADDR_STATUS_A:   rdata_next = status_a_word;
            `PSCB_ADDR_STATUS_B:   rdata_next = status_b_word;
            `PSCB_ADDR_MAC_CONFIG: rdata_next = mac_interface_config;
            `PSCB_ADDR_CONFIG_B:   rdata_next = peripheral_enable_config_b;
            `PSCB_ADDR_EMU_PD:     rdata_next = emulator_buffer_powerdown;
            default:               rdata_next = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Answer one cycle after each read or refused request; writes get no answer; foreign masters get zero data.
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            bus_rdata   <= 32'h00000000;
            bus_rvalid  <= 1'b0;
            bus_refused <= 1'b0;
        end else begin
            bus_rvalid  <= bus_req && !bus_we && allowed;
            bus_refused <= bus_req && !allowed;
            if (bus_req && !bus_we && allowed) begin
                bus_rdata <= rdata_next;
            end else if (bus_req) begin
                bus_rdata <= 32'h00000000;
            end
        end
    end

endmodule

/* hdl/pscb_consts.vh */
// Offsets, field positions, reset values and timing counts of the state control bank.
`ifndef PSCB_CONSTS_VH
`define PSCB_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define PSCB_ADDR_UNLOCK_KEY   32'h02ac0004
`define PSCB_ADDR_CONFIG_A     32'h02ac0008
`define PSCB_ADDR_STATUS_A     32'h02ac0014
`define PSCB_ADDR_STATUS_B     32'h02ac0018
`define PSCB_ADDR_MAC_CONFIG   32'h02ac0020
`define PSCB_ADDR_CONFIG_B     32'h02ac002c
`define PSCB_ADDR_EMU_PD       32'h02ac0054

// ----------------------------------------------------------------------------
// Reset values, key and masks
// ----------------------------------------------------------------------------
`define PSCB_UNLOCK_RESET      32'hf0f0f0f0
`define PSCB_UNLOCK_KEY        32'h0f0a0b00
`define PSCB_CONFIG_A_RESET    32'h00000000
`define PSCB_CONFIG_A_MASK     32'h00155550
`define PSCB_PLAIN_RESET       32'h00000000

// ----------------------------------------------------------------------------
// Enable bit positions in the first configuration register
// ----------------------------------------------------------------------------
`define PSCB_BIT_PCI           20
`define PSCB_BIT_HOST_PORT     18
`define PSCB_BIT_SERIAL_ONE    16
`define PSCB_BIT_SERIAL_ZERO   14
`define PSCB_BIT_I2C           12
`define PSCB_BIT_GPIO          10
`define PSCB_BIT_TIMER_ZERO    8
`define PSCB_BIT_TIMER_ONE     6
`define PSCB_BIT_MAC           4

// ----------------------------------------------------------------------------
// Status field low bits in the first status register; PCI sits in the second
// ----------------------------------------------------------------------------
`define PSCB_STAT_HOST_PORT    27
`define PSCB_STAT_SERIAL_ONE   24
`define PSCB_STAT_SERIAL_ZERO  21
`define PSCB_STAT_I2C          18
`define PSCB_STAT_GPIO         15
`define PSCB_STAT_TIMER_ONE    12
`define PSCB_STAT_TIMER_ZERO   9
`define PSCB_STAT_MAC          6
`define PSCB_STAT_PCI          0

// ----------------------------------------------------------------------------
// Status codes, boot selections, masters and timing
// ----------------------------------------------------------------------------
`define PSCB_ST_DISABLED       3'h0
`define PSCB_ST_ENABLED        3'h1
`define PSCB_ST_STATIC_PD      3'h3
`define PSCB_ST_IN_PROGRESS    3'h5
`define PSCB_BOOT_PCI          4'h7
`define PSCB_BOOT_HOST_PORT    4'h1
`define PSCB_MASTER_CPU        2'h0
`define PSCB_MASTER_EMU        2'h1
`define PSCB_WINDOW_CYCLES     16
`define PSCB_ENABLE_CYCLES     16
`define PSCB_STRAP_SETTLE      3

`endif

/* hdl/pscb_periph_state.v */
// Per-peripheral state tracker: disabled, enable in progress, enabled, static powerdown.
`timescale 1ns/100ps
`include "pscb_consts.vh"

module pscb_periph_state #(
    parameter LATENCY = `PSCB_ENABLE_CYCLES
) (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       mode_ctl,
    input  wire       static_pd,
    output reg        periph_enable,
    output reg  [2:0] periph_status
);

    localparam [1:0] ST_DIS  = 2'h0;
    localparam [1:0] ST_PROG = 2'h1;
    localparam [1:0] ST_ENA  = 2'h2;
    localparam [1:0] ST_PD   = 2'h3;
    localparam [5:0] LAT_M1  = LATENCY - 1;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [5:0] wait_reg;
    reg [5:0] wait_next;

    // ------------------------------------------------------------------------
    // Next state: a static powerdown strap wins over any control bit.
    // ------------------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        wait_next  = wait_reg;
        case (state_reg)
            ST_DIS: begin
                if (static_pd) begin
                    state_next = ST_PD;
                end else if (mode_ctl) begin
                    state_next = ST_PROG;
                    wait_next  = LAT_M1;
                end
            end
            ST_PROG: begin
                if (static_pd) begin
                    state_next = ST_PD;
                end else if (!mode_ctl) begin
                    state_next = ST_DIS;
                end else if (wait_reg == 6'h00) begin
                    state_next = ST_ENA;
                end else begin
                    wait_next = wait_reg - 6'h01;
                end
            end
            ST_ENA: begin
                if (static_pd) begin
                    state_next = ST_PD;
                end else if (!mode_ctl) begin
                    state_next = ST_DIS;
                end
            end
            ST_PD: begin
                if (!static_pd) begin
                    state_next = ST_DIS;
                end
            end
            default: begin
                state_next = ST_DIS;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // State, enable and status flops; reset leaves the peripheral disabled.
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            state_reg     <= ST_DIS;
            wait_reg      <= 6'h00;
            periph_enable <= 1'b0;
            periph_status <= `PSCB_ST_DISABLED;
        end else begin
            state_reg     <= state_next;
            wait_reg      <= wait_next;
            periph_enable <= (state_next == ST_ENA);
            case (state_next)
                ST_PROG: periph_status <= `PSCB_ST_IN_PROGRESS;
                ST_ENA:  periph_status <= `PSCB_ST_ENABLED;
                ST_PD:   periph_status <= `PSCB_ST_STATIC_PD;
                default: periph_status <= `PSCB_ST_DISABLED;
            endcase
        end
    end

endmodule

/* sim/pscb_bank_props.sv */
// Concurrent checks on the state control bank ports.
`timescale 1ns/100ps
`include "pscb_consts.vh"
module pscb_bank_props #(
    parameter WINDOW_CYCLES = 16
) (
    input wire        clk_sys,
    input wire        rst,
    input wire        bus_req,
    input wire        bus_we,
    input wire [31:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire [1:0]  bus_master,
    input wire [31:0] bus_rdata,
    input wire        bus_rvalid,
    input wire        bus_refused,
    input wire [8:0]  periph_enable,
    input wire        config_a_unlocked,
    input wire [31:0] peripheral_enable_config_b
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // --------------------
    // Helper logic
    // --------------------
    // Allowed and key writes.
    wire       ok_w  = bus_req && bus_we && !bus_master[1];
    wire       key_w = ok_w && bus_addr == `PSCB_ADDR_UNLOCK_KEY;
    reg  [6:0] open_cnt;
    // Open cycles since the key.
    always @(posedge clk_sys) begin
        if (rst)
            open_cnt <= 7'h00;
        else if (key_w && bus_wdata == `PSCB_UNLOCK_KEY)
            open_cnt <= 7'h01;
        else if (config_a_unlocked)
            open_cnt <= open_cnt + 7'h01;
        else
            open_cnt <= 7'h00;
    end
    // The two steps of a key readback.
    sequence s_key_wr;
        key_w;
    endsequence
    sequence s_key_rd;
        bus_req && !bus_we && !bus_master[1] && bus_addr == `PSCB_ADDR_UNLOCK_KEY;
    endsequence
    // --------------------
    // Assertions
    // --------------------
    AST_KEY_OPENS: assert property (key_w && bus_wdata == `PSCB_UNLOCK_KEY |=> config_a_unlocked)
        else $error("window closed after the key");
    AST_WINDOW_BOUND: assert property (config_a_unlocked |-> open_cnt <= WINDOW_CYCLES)
        else $error("window open too long");
    AST_ONE_WRITE: assert property (ok_w && bus_addr == `PSCB_ADDR_CONFIG_A && config_a_unlocked
        |=> !config_a_unlocked) else $error("window open after a write");
    AST_BAD_KEY: assert property (key_w && bus_wdata != `PSCB_UNLOCK_KEY |=> !config_a_unlocked)
        else $error("window open after a wrong key");
    AST_KEY_READBACK: assert property (s_key_wr ##2 s_key_rd |=> bus_rdata == $past(bus_wdata, 3))
        else $error("key register readback differs");
    AST_REFUSED: assert property (bus_req && bus_master[1] |=> bus_refused && !bus_rvalid && bus_rdata == 32'h0)
        else $error("foreign master not refused");
    AST_READ_ANSWER: assert property (bus_req && !bus_we && !bus_master[1] |=> bus_rvalid && !bus_refused)
        else $error("read got no answer");
    AST_CFGB_DIRECT: assert property (ok_w && bus_addr == `PSCB_ADDR_CONFIG_B
        |=> peripheral_enable_config_b == $past(bus_wdata)) else $error("config b write lost");
    AST_RESET_QUIET: assert property ($past(rst) |-> periph_enable == 9'h000 && !config_a_unlocked)
        else $error("peripheral enabled out of reset");
endmodule
bind pscb_bank pscb_bank_props #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_props (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_master(bus_master), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .bus_refused(bus_refused), .periph_enable(periph_enable), .config_a_unlocked(config_a_unlocked),
    .peripheral_enable_config_b(peripheral_enable_config_b));

/* sim/tb_pscb_bank.sv */
// Self-checking bench for the state control bank.
`timescale 1ns/100ps
`include "pscb_consts.vh"
module tb_pscb_bank;
    localparam EN_CYC = 4;
    localparam [44:0] BITS = {5'h04, 5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h12, 5'h14};
    localparam [35:0] IDX  = {4'h7, 4'h5, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0, 4'h8};
    reg         clk_sys, rst, bus_req, bus_we, pd_mac, rd_ok, rd_ref;
    reg  [31:0] bus_addr, bus_wdata, rd_val;
    reg  [1:0]  bus_master;
    reg  [3:0]  boot_sel;
    wire [31:0] bus_rdata, cfg_b;
    wire        bus_rvalid, bus_refused, unlocked;
    wire [8:0]  periph_enable;
    integer     n_errors, cmp_count, i;
    integer     cyc = 0;
    pscb_bank #(.WINDOW_CYCLES(16), .ENABLE_CYCLES(EN_CYC)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_master(bus_master), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid), .bus_refused(bus_refused), .boot_select_field(boot_sel),
        .pd_strap_host_port(1'b0), .pd_strap_pci(1'b0), .pd_strap_serial_one(1'b0),
        .pd_strap_mac(pd_mac), .periph_enable(periph_enable), .config_a_unlocked(unlocked),
        .mac_interface_config(), .peripheral_enable_config_b(cfg_b), .emulator_buffer_powerdown());
    // --------------------
    // Shared tasks
    // --------------------
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // One access; answer caught one cycle later.
    task acc(input we, input [31:0] a, input [31:0] d, input [1:0] m);
        begin
            bus_req = 1'b1;
            bus_we = we;
            bus_addr = a;
            bus_wdata = d;
            bus_master = m;
            @(posedge clk_sys);
            #1;
            bus_req = 1'b0;
            rd_val = bus_rdata;
            rd_ok = bus_rvalid;
            rd_ref = bus_refused;
            @(posedge clk_sys);
            #1;
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        acc(1'b1, a, d, `PSCB_MASTER_CPU);
    endtask
    task rd(input [31:0] a);
        acc(1'b0, a, 32'h0, `PSCB_MASTER_CPU);
    endtask
    task idle(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    task do_reset(input [3:0] bs, input pm);
        begin
            rst = 1'b1;
            boot_sel = bs;
            pd_mac = pm;
            idle(12);
            rst = 1'b0;
            idle(6);
        end
    endtask
    task close_out;
        begin
            $display("compares=%0d errors=%0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // --------------------
    // Scenarios
    // --------------------
    task t_boot;
        begin
            do_reset(`PSCB_BOOT_PCI, 1'b0);
            rd(`PSCB_ADDR_CONFIG_A);
            chk(rd_val, 32'h00100000);
            do_reset(`PSCB_BOOT_HOST_PORT, 1'b1);
            rd(`PSCB_ADDR_CONFIG_A);
            chk(rd_val, 32'h00040000);
            rd(`PSCB_ADDR_STATUS_A);
            chk({29'h0, rd_val[8:6]}, 32'h3);
            idle(EN_CYC + 4);
            chk({23'h0, periph_enable}, 32'h1);
        end
    endtask
    task t_defaults;
        begin
            do_reset(4'h0, 1'b0);
            rd(`PSCB_ADDR_UNLOCK_KEY);
            chk(rd_val, `PSCB_UNLOCK_RESET);
            rd(`PSCB_ADDR_CONFIG_A);
            chk(rd_val | {23'h0, periph_enable}, 32'h0);
            rd(`PSCB_ADDR_STATUS_A);
            chk(rd_val, 32'h0);
        end
    endtask
    // Each enable bit alone, reserved bits written high.
    task t_bits;
        for (i = 0; i < 9; i = i + 1) begin
            wr(`PSCB_ADDR_UNLOCK_KEY, `PSCB_UNLOCK_KEY);
            wr(`PSCB_ADDR_CONFIG_A, 32'hffeaaaaf | (32'h1 << BITS[i*5 +: 5]));
            rd(`PSCB_ADDR_CONFIG_A);
            chk(rd_val, 32'h1 << BITS[i*5 +: 5]);
            idle(EN_CYC + 4);
            chk({23'h0, periph_enable}, 32'h1 << IDX[i*4 +: 4]);
        end
    endtask
    task t_window;
        begin
            wr(`PSCB_ADDR_UNLOCK_KEY, `PSCB_UNLOCK_KEY);
            idle(14);
            wr(`PSCB_ADDR_CONFIG_A, 32'h00001000);
            wr(`PSCB_ADDR_CONFIG_A, 32'h00000400);
            rd(`PSCB_ADDR_CONFIG_A);
            chk(rd_val, 32'h00001000);
            wr(`PSCB_ADDR_UNLOCK_KEY, `PSCB_UNLOCK_KEY);
            idle(15);
            wr(`PSCB_ADDR_CONFIG_A, 32'h00000040);
            wr(`PSCB_ADDR_UNLOCK_KEY, `PSCB_UNLOCK_KEY);
            wr(`PSCB_ADDR_UNLOCK_KEY, 32'h0f0a0b01);
            rd(`PSCB_ADDR_UNLOCK_KEY);
            chk(rd_val, 32'h0f0a0b01);
            wr(`PSCB_ADDR_CONFIG_A, 32'h00000040);
            rd(`PSCB_ADDR_CONFIG_A);
            chk(rd_val, 32'h00001000);
        end
    endtask
    task t_master;
        begin
            acc(1'b1, `PSCB_ADDR_CONFIG_B, 32'ha5a55a5a, 2'h2);
            chk({31'h0, rd_ref}, 32'h1);
            acc(1'b0, `PSCB_ADDR_CONFIG_B, 32'h0, 2'h3);
            chk({rd_val[31:1], rd_ref}, 32'h1);
            acc(1'b1, `PSCB_ADDR_CONFIG_B, 32'h3c3cc3c3, `PSCB_MASTER_EMU);
            acc(1'b0, `PSCB_ADDR_CONFIG_B, 32'h0, `PSCB_MASTER_EMU);
            chk({rd_val[31:1], rd_ok}, 32'h3c3cc3c3);
            chk(cfg_b, 32'h3c3cc3c3);
            rd(32'h02ac000c);
            chk(rd_val, 32'h0);
        end
    endtask
    // --------------------
    // Clock, watchdog and main sequence
    // --------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Cuts a hung run short.
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            n_errors = n_errors + 1;
            close_out;
        end
    end
    initial begin
        rst = 1'b1;
        {bus_req, bus_we, pd_mac, bus_addr, bus_wdata, bus_master, boot_sel} = 73'h0;
        n_errors = 0;
        cmp_count = 0;
        t_boot;
        t_defaults;
        t_bits;
        t_window;
        t_master;
        close_out;
    end
endmodule
